// File: rtl/dhs_pkg.sv
package dhs_pkg;

    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_METHOD = 8'h04;
    localparam logic [7:0] ADDR_HOME_SPEED = 8'h08;
    localparam logic [7:0] ADDR_CREEP_SPEED = 8'h0C;
    localparam logic [7:0] ADDR_SHIFT = 8'h10;
    localparam logic [7:0] ADDR_HOME_DATA = 8'h14;
    localparam logic [7:0] ADDR_POST_DOG = 8'h18;
    localparam logic [7:0] ADDR_POLARITY = 8'h1C;
    localparam logic [7:0] ADDR_ACCEL = 8'h20;
    localparam logic [7:0] ADDR_DECEL = 8'h24;
    localparam logic [7:0] ADDR_PROG = 8'h28;
    localparam logic [7:0] ADDR_STATUS = 8'h2C;
    localparam logic [7:0] ADDR_POSITION = 8'h30;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h34;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h38;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h3C;

    // Field positions
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_ABORT_BIT = 1;
    localparam int METHOD_DIR_BIT = 4;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_ALARM_BIT = 1;
    localparam int IRQ_DOG_BIT = 2;
    localparam int IRQ_W = 3;

    // Homing method codes
    localparam logic [3:0] CODE_REAR_END = 4'h5;
    localparam logic [3:0] CODE_COUNT = 4'h6;
    localparam logic [3:0] CODE_CRADLE = 4'h7;

    // Values after reset
    localparam logic [4:0] METHOD_RST = 5'h05;
    localparam logic [15:0] HOME_SPEED_RST = 16'h0064;
    localparam logic [15:0] CREEP_SPEED_RST = 16'h000A;
    localparam logic [15:0] TC_RST = 16'h0000;
    localparam logic POLARITY_RST = 1'b1;
    localparam logic [3:0] PROG_RST = 4'h0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_FAST = 3'b001,
        ST_CREEP = 3'b010,
        ST_TRAVEL = 3'b011,
        ST_DONE = 3'b100,
        ST_ALARM = 3'b101
    } dhs_state_e;

    // Pin inputs crossing into the clock domain
    typedef struct packed {
        logic dog;
        logic zphase;
        logic mode_sel;
        logic enc_pulse;
        logic [3:0] prog_sel;
    } dhs_pins_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } dhs_bus_s;

endpackage

// File: rtl/dhs_dog_homing_sequencer.sv
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/10ps
`default_nettype none

module dhs_dog_homing_sequencer #(
    parameter int SPEED_W = 16,
    parameter int POS_W = 32
) (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic dog_i,
    input wire logic zphase_i,
    input wire logic operation_mode_select_1_i,
    input wire logic enc_pulse_i,
    input wire logic [3:0] program_select_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rd_data_o,
    output logic [SPEED_W-1:0] speed_cmd_o,
    output logic dir_o,
    output logic homing_complete_o,
    output logic homing_incomplete_alarm_o,
    output logic irq_o
);

    dhs_pkg::dhs_pins_s pins_raw;
    dhs_pkg::dhs_pins_s sync1_reg;
    dhs_pkg::dhs_pins_s sync2_reg;
    dhs_pkg::dhs_pins_s prev_reg;
    dhs_pkg::dhs_bus_s bus;
    dhs_pkg::dhs_state_e state_reg;
    dhs_pkg::dhs_state_e state_next;

    logic [4:0] homing_method_setting_reg;
    logic [SPEED_W-1:0] homing_speed_setting_reg;
    logic [SPEED_W-1:0] creep_speed_setting_reg;
    logic [POS_W-1:0] home_shift_distance_setting_reg;
    logic [POS_W-1:0] home_position_data_setting_reg;
    logic [POS_W-1:0] post_dog_travel_setting_reg;
    logic dog_polarity_setting_reg;
    logic [15:0] homing_accel_time_constant_reg;
    logic [15:0] homing_decel_time_constant_reg;
    logic [3:0] homing_prog_reg;
    logic [dhs_pkg::IRQ_W-1:0] irq_status_reg;
    logic [dhs_pkg::IRQ_W-1:0] irq_enable_reg;
    logic [dhs_pkg::IRQ_W-1:0] irq_event;
    logic [SPEED_W-1:0] speed_reg;
    logic [SPEED_W-1:0] target_speed;
    logic [15:0] ramp_cnt_reg;
    logic [15:0] ramp_limit;
    logic [POS_W-1:0] position_reg;
    logic [POS_W-1:0] dist_reg;
    logic [POS_W-1:0] dist_target;
    logic dog_active;
    logic dog_prev_active;
    logic dog_lead;
    logic dog_trail;
    logic z_edge;
    logic enc_edge;
    logic method_ok;
    logic start;
    logic abort;
    logic ramp_tick;
    logic travel_end;
    logic complete_reg;
    logic alarm_reg;
    logic dir_reg;

    assign pins_raw = '{dog: dog_i, zphase: zphase_i,
        mode_sel: operation_mode_select_1_i, enc_pulse: enc_pulse_i,
        prog_sel: program_select_i};
    assign bus = '{addr: addr_i, wdata: wr_data_i, wr: wr_i, rd: rd_i};

    // Two flops on every pin; the extra latency is part of the home error
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            prev_reg <= '0;
        end else begin
            sync1_reg <= pins_raw;
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end

    assign dog_active = sync2_reg.dog ~^ dog_polarity_setting_reg;
    assign dog_prev_active = prev_reg.dog ~^ dog_polarity_setting_reg;
    assign dog_lead = dog_active && !dog_prev_active;
    assign dog_trail = !dog_active && dog_prev_active;
    assign z_edge = sync2_reg.zphase && !prev_reg.zphase;
    assign enc_edge = sync2_reg.enc_pulse && !prev_reg.enc_pulse;

    assign method_ok = (homing_method_setting_reg[3:0] == dhs_pkg::CODE_REAR_END)
        || (homing_method_setting_reg[3:0] == dhs_pkg::CODE_COUNT)
        || (homing_method_setting_reg[3:0] == dhs_pkg::CODE_CRADLE);
    // Start needs program mode and the program that holds the homing command
    assign start = bus.wr && (bus.addr == dhs_pkg::ADDR_CTRL)
        && bus.wdata[dhs_pkg::CTRL_START_BIT]
        && sync2_reg.mode_sel
        && (sync2_reg.prog_sel == homing_prog_reg)
        && method_ok;
    assign abort = bus.wr && (bus.addr == dhs_pkg::ADDR_CTRL)
        && bus.wdata[dhs_pkg::CTRL_ABORT_BIT];

    // Configuration registers
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            homing_method_setting_reg <= dhs_pkg::METHOD_RST;
            homing_speed_setting_reg <= SPEED_W'(dhs_pkg::HOME_SPEED_RST);
            creep_speed_setting_reg <= SPEED_W'(dhs_pkg::CREEP_SPEED_RST);
            home_shift_distance_setting_reg <= '0;
            home_position_data_setting_reg <= '0;
            post_dog_travel_setting_reg <= '0;
            dog_polarity_setting_reg <= dhs_pkg::POLARITY_RST;
            homing_accel_time_constant_reg <= dhs_pkg::TC_RST;
            homing_decel_time_constant_reg <= dhs_pkg::TC_RST;
            homing_prog_reg <= dhs_pkg::PROG_RST;
            irq_enable_reg <= '0;
        end else if (bus.wr) begin
            case (bus.addr)
                dhs_pkg::ADDR_METHOD: begin
                    homing_method_setting_reg <= bus.wdata[4:0];
                end
                dhs_pkg::ADDR_HOME_SPEED: begin
                    homing_speed_setting_reg <= bus.wdata[SPEED_W-1:0];
                end
                dhs_pkg::ADDR_CREEP_SPEED: begin
                    creep_speed_setting_reg <= bus.wdata[SPEED_W-1:0];
                end
                dhs_pkg::ADDR_SHIFT: begin
                    home_shift_distance_setting_reg <= bus.wdata[POS_W-1:0];
                end
                dhs_pkg::ADDR_HOME_DATA: begin
                    home_position_data_setting_reg <= bus.wdata[POS_W-1:0];
                end
                dhs_pkg::ADDR_POST_DOG: begin
                    post_dog_travel_setting_reg <= bus.wdata[POS_W-1:0];
                end
                dhs_pkg::ADDR_POLARITY: begin
                    dog_polarity_setting_reg <= bus.wdata[0];
                end
                dhs_pkg::ADDR_ACCEL: begin
                    homing_accel_time_constant_reg <= bus.wdata[15:0];
                end
                dhs_pkg::ADDR_DECEL: begin
                    homing_decel_time_constant_reg <= bus.wdata[15:0];
                end
                dhs_pkg::ADDR_PROG: begin
                    homing_prog_reg <= bus.wdata[3:0];
                end
                dhs_pkg::ADDR_IRQ_ENABLE: begin
                    irq_enable_reg <= bus.wdata[dhs_pkg::IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Sequencer
    assign dist_target = post_dog_travel_setting_reg
        + home_shift_distance_setting_reg;
    assign travel_end = (state_reg == dhs_pkg::ST_TRAVEL)
        && (dist_reg >= dist_target);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            dhs_pkg::ST_IDLE, dhs_pkg::ST_DONE, dhs_pkg::ST_ALARM: begin
                if (start) begin
                    state_next = dhs_pkg::ST_FAST;
                end
            end
            dhs_pkg::ST_FAST: begin
                if (dog_lead) begin
                    if (homing_method_setting_reg[3:0] == dhs_pkg::CODE_COUNT) begin
                        state_next = dhs_pkg::ST_TRAVEL;
                    end else begin
                        state_next = dhs_pkg::ST_CREEP;
                    end
                end
            end
            dhs_pkg::ST_CREEP: begin
                if (homing_method_setting_reg[3:0] == dhs_pkg::CODE_CRADLE) begin
                    if (z_edge) begin
                        state_next = dhs_pkg::ST_DONE;
                    end
                end else if (dog_trail) begin
                    // Trailing edge alone ends creep; Z is never looked at
                    state_next = dhs_pkg::ST_TRAVEL;
                end
            end
            dhs_pkg::ST_TRAVEL: begin
                if (travel_end) begin
                    if ((homing_method_setting_reg[3:0] == dhs_pkg::CODE_COUNT)
                        && (speed_reg != creep_speed_setting_reg)) begin
                        state_next = dhs_pkg::ST_ALARM;
                    end else begin
                        state_next = dhs_pkg::ST_DONE;
                    end
                end
            end
            default: begin
                state_next = dhs_pkg::ST_IDLE;
            end
        endcase
        if (abort) begin
            state_next = dhs_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_reg <= dhs_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Travel distance counts encoder pulses from the reference edge
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dist_reg <= '0;
        end else if (state_reg != dhs_pkg::ST_TRAVEL) begin
            dist_reg <= '0;
        end else if (enc_edge) begin
            dist_reg <= dist_reg + 1'b1;
        end
    end

    // Direction is latched at start so a mid-run write cannot reverse
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dir_reg <= 1'b0;
        end else if (start) begin
            dir_reg <= homing_method_setting_reg[dhs_pkg::METHOD_DIR_BIT];
        end
    end

    // Speed profile
    always_comb begin
        case (state_reg)
            dhs_pkg::ST_FAST: target_speed = homing_speed_setting_reg;
            dhs_pkg::ST_CREEP,
            dhs_pkg::ST_TRAVEL: target_speed = creep_speed_setting_reg;
            default: target_speed = '0;
        endcase
    end

    assign ramp_limit = (target_speed > speed_reg) ?
        homing_accel_time_constant_reg : homing_decel_time_constant_reg;
    assign ramp_tick = (ramp_cnt_reg >= ramp_limit);

    // One speed step per time constant plus one cycle; stop is immediate
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ramp_cnt_reg <= '0;
            speed_reg <= '0;
        end else if (state_next != state_reg || speed_reg == target_speed) begin
            ramp_cnt_reg <= '0;
            if (state_next == dhs_pkg::ST_IDLE || state_next == dhs_pkg::ST_DONE
                || state_next == dhs_pkg::ST_ALARM) begin
                speed_reg <= '0;
            end
        end else if (ramp_tick) begin
            ramp_cnt_reg <= '0;
            if (target_speed > speed_reg) begin
                speed_reg <= speed_reg + 1'b1;
            end else begin
                speed_reg <= speed_reg - 1'b1;
            end
        end else begin
            ramp_cnt_reg <= ramp_cnt_reg + 1'b1;
        end
    end

    // Position, completion and alarm
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            position_reg <= '0;
        end else if (state_next == dhs_pkg::ST_DONE
            && state_reg != dhs_pkg::ST_DONE) begin
            position_reg <= home_position_data_setting_reg;
        end else if (enc_edge) begin
            position_reg <= dir_reg ? position_reg - 1'b1 : position_reg + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            complete_reg <= 1'b0;
            alarm_reg <= 1'b0;
        end else begin
            complete_reg <= (state_next == dhs_pkg::ST_DONE);
            alarm_reg <= (state_next == dhs_pkg::ST_ALARM);
        end
    end

    // Interrupts: set wins over a clear in the same cycle
    assign irq_event[dhs_pkg::IRQ_DONE_BIT] = (state_next == dhs_pkg::ST_DONE)
        && (state_reg != dhs_pkg::ST_DONE);
    assign irq_event[dhs_pkg::IRQ_ALARM_BIT] = (state_next == dhs_pkg::ST_ALARM)
        && (state_reg != dhs_pkg::ST_ALARM);
    assign irq_event[dhs_pkg::IRQ_DOG_BIT] = dog_lead
        && (state_reg == dhs_pkg::ST_FAST);

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_status_reg <= '0;
        end else if (bus.wr && bus.addr == dhs_pkg::ADDR_IRQ_CLEAR) begin
            irq_status_reg <= (irq_status_reg
                & ~bus.wdata[dhs_pkg::IRQ_W-1:0]) | irq_event;
        end else begin
            irq_status_reg <= irq_status_reg | irq_event;
        end
    end

    // Read data stands for one cycle only
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_data_o <= '0;
        end else if (!bus.rd) begin
            rd_data_o <= '0;
        end else begin
            case (bus.addr)
                dhs_pkg::ADDR_METHOD: rd_data_o <= 32'(homing_method_setting_reg);
                dhs_pkg::ADDR_HOME_SPEED: rd_data_o <= 32'(homing_speed_setting_reg);
                dhs_pkg::ADDR_CREEP_SPEED: rd_data_o <= 32'(creep_speed_setting_reg);
                dhs_pkg::ADDR_SHIFT: rd_data_o <= 32'(home_shift_distance_setting_reg);
                dhs_pkg::ADDR_HOME_DATA: rd_data_o <= 32'(home_position_data_setting_reg);
                dhs_pkg::ADDR_POST_DOG: rd_data_o <= 32'(post_dog_travel_setting_reg);
                dhs_pkg::ADDR_POLARITY: rd_data_o <= 32'(dog_polarity_setting_reg);
                dhs_pkg::ADDR_ACCEL: rd_data_o <= 32'(homing_accel_time_constant_reg);
                dhs_pkg::ADDR_DECEL: rd_data_o <= 32'(homing_decel_time_constant_reg);
                dhs_pkg::ADDR_PROG: rd_data_o <= 32'(homing_prog_reg);
                dhs_pkg::ADDR_STATUS: begin
                    rd_data_o <= {8'h00, 8'(speed_reg), 10'h000,
                        dog_active, alarm_reg, complete_reg, 3'(state_reg)};
                end
                dhs_pkg::ADDR_POSITION: rd_data_o <= 32'(position_reg);
                dhs_pkg::ADDR_IRQ_STATUS: rd_data_o <= 32'(irq_status_reg);
                dhs_pkg::ADDR_IRQ_ENABLE: rd_data_o <= 32'(irq_enable_reg);
                default: rd_data_o <= 32'h0000_0000;
            endcase
        end
    end

    // Outputs from flops
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            speed_cmd_o <= '0;
            dir_o <= 1'b0;
            homing_complete_o <= 1'b0;
            homing_incomplete_alarm_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            speed_cmd_o <= speed_reg;
            dir_o <= dir_reg;
            homing_complete_o <= complete_reg;
            homing_incomplete_alarm_o <= alarm_reg;
            irq_o <= |(irq_status_reg & irq_enable_reg);
        end
    end

endmodule

`default_nettype wire

// File: verification/dhs_asserts.sv
`timescale 1ns/10ps
`default_nettype none

module dhs_asserts #(
    parameter int SPEED_W = 16
) (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rd_data_o,
    input wire logic [SPEED_W-1:0] speed_cmd_o,
    input wire logic dir_o,
    input wire logic homing_complete_o,
    input wire logic homing_incomplete_alarm_o,
    input wire logic irq_o
);
    logic [SPEED_W-1:0] hs_sh;
    logic [SPEED_W-1:0] cr_sh;
    logic [4:0] meth_sh;
    logic [dhs_pkg::IRQ_W-1:0] en_sh;
    logic ctrl_wr;

    assign ctrl_wr = wr_i && addr_i == dhs_pkg::ADDR_CTRL;

    // Shadows of settings, so limits follow what software wrote
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hs_sh <= SPEED_W'(dhs_pkg::HOME_SPEED_RST);
            cr_sh <= SPEED_W'(dhs_pkg::CREEP_SPEED_RST);
            meth_sh <= dhs_pkg::METHOD_RST;
            en_sh <= '0;
        end else if (wr_i) begin
            case (addr_i)
                dhs_pkg::ADDR_HOME_SPEED: hs_sh <= wr_data_i[SPEED_W-1:0];
                dhs_pkg::ADDR_CREEP_SPEED: cr_sh <= wr_data_i[SPEED_W-1:0];
                dhs_pkg::ADDR_METHOD: meth_sh <= wr_data_i[4:0];
                dhs_pkg::ADDR_IRQ_ENABLE: en_sh <= wr_data_i[2:0];
                default: ;
            endcase
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);

    a_rd_idle_zero:
        assert property (!$past(rd_i) |-> rd_data_o == 32'h0000_0000)
        else $error("read data not zero outside read slot");
    a_speed_cap:
        assert property (speed_cmd_o <= hs_sh || speed_cmd_o <= cr_sh)
        else $error("speed above configured speeds");
    a_speed_step:
        assert property (speed_cmd_o != '0 |->
            {1'b0, speed_cmd_o} <= {1'b0, $past(speed_cmd_o)} + 1'b1 &&
            {1'b0, speed_cmd_o} + 1'b1 >= {1'b0, $past(speed_cmd_o)})
        else $error("speed changed by more than one step");
    a_stop_at_home:
        assert property ($rose(homing_complete_o) |-> speed_cmd_o == '0)
        else $error("motor still commanded at completion");
    a_dir_method:
        assert property ($rose(homing_complete_o) |->
            dir_o == meth_sh[dhs_pkg::METHOD_DIR_BIT])
        else $error("direction differs from method setting");
    a_alarm_count:
        assert property ($rose(homing_incomplete_alarm_o) |->
            meth_sh[3:0] == dhs_pkg::CODE_COUNT)
        else $error("alarm outside count method");
    a_complete_hold:
        assert property (homing_complete_o && !ctrl_wr && !$past(ctrl_wr)
            |=> homing_complete_o)
        else $error("complete dropped without command");
    a_irq_masked:
        assert property (en_sh == '0 && $past(en_sh) == '0 |-> !irq_o)
        else $error("interrupt high while all masked");

    c_done: cover property ($rose(homing_complete_o));
    c_alarm: cover property ($rose(homing_incomplete_alarm_o));
    c_irq: cover property ($rose(irq_o));
endmodule

bind dhs_dog_homing_sequencer dhs_asserts #(.SPEED_W(SPEED_W)) dhs_asserts_i (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
    .speed_cmd_o(speed_cmd_o), .dir_o(dir_o),
    .homing_complete_o(homing_complete_o),
    .homing_incomplete_alarm_o(homing_incomplete_alarm_o), .irq_o(irq_o)
);

`default_nettype wire

// File: verification/dhs_far_model.sv
`timescale 1ns/10ps
`default_nettype none

module dhs_far_model #(
    parameter int DOG_LO = 20,
    parameter int DOG_HI = 40,
    parameter int ZPER = 16
) (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic [15:0] speed_i,
    input wire logic pol_i,
    input wire logic z_en_i,
    input wire logic clr_i,
    output logic dog_o,
    output logic zphase_o,
    output logic enc_pulse_o,
    output logic [15:0] trav_o
);
    logic [1:0] ph;

    // A started pulse is finished, so no stray edge follows a stop
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ph <= 2'h0;
            trav_o <= 16'h0000;
        end else if (clr_i) begin
            ph <= 2'h0;
            trav_o <= 16'h0000;
        end else if (speed_i != 16'h0000 || ph[1]) begin
            ph <= ph + 2'h1;
            if (ph == 2'h1)
                trav_o <= trav_o + 16'h0001;
        end
    end

    assign enc_pulse_o = ph[1];
    // Pin shows the dog at the configured active level
    assign dog_o = (trav_o >= DOG_LO && trav_o < DOG_HI) == pol_i;
    // One marker per ZPER counts; one before the dog must be ignored
    assign zphase_o = z_en_i && (int'(trav_o) % ZPER == ZPER - 1);
endmodule

`default_nettype wire

// File: verification/dhs_dog_homing_sequencer_tb.sv
`timescale 1ns/10ps
`default_nettype none

module dhs_dog_homing_sequencer_tb;
    localparam logic [31:0] HOME = 32'h0000_1234;
    logic clk_sys_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic mode = 1'b1;
    logic [3:0] prog = 4'h0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic pol_m = 1'b1;
    logic z_en = 1'b0;
    logic clr = 1'b1;
    logic dog, zph, enc, dir, cmp, alm, irq;
    logic [31:0] rdat;
    logic [15:0] spd, mx, lst, trav;
    int num_errors = 0;
    int n_tests = 0;

    dhs_dog_homing_sequencer dhs_dog_homing_sequencer_i (
        .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .dog_i(dog),
        .zphase_i(zph), .operation_mode_select_1_i(mode),
        .enc_pulse_i(enc), .program_select_i(prog), .addr_i(addr),
        .wr_data_i(wdat), .wr_i(wr), .rd_i(rd), .rd_data_o(rdat),
        .speed_cmd_o(spd), .dir_o(dir), .homing_complete_o(cmp),
        .homing_incomplete_alarm_o(alm), .irq_o(irq)
    );
    dhs_far_model dhs_far_model_i (
        .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .speed_i(spd),
        .pol_i(pol_m), .z_en_i(z_en), .clr_i(clr), .dog_o(dog),
        .zphase_o(zph), .enc_pulse_o(enc), .trav_o(trav)
    );

    initial begin
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end

    always @(posedge clk_sys_i) begin
        if (clr) begin
            mx <= 16'h0000;
            lst <= 16'h0000;
        end else begin
            if (spd > mx)
                mx <= spd;
            if (spd != 16'h0000)
                lst <= spd;
        end
    end

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        addr <= a;
        wdat <= d;
        wr <= 1'b1;
        @(posedge clk_sys_i);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys_i);
        rd <= 1'b0;
        #1 d = rdat;
    endtask

    task automatic chk(string n, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", n, e, g);
            num_errors++;
        end
    endtask

    task automatic end_sim();
        if (num_errors == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic t_regs();
        logic [7:0] a[6] = '{8'h04, 8'h08, 8'h0C, 8'h1C, 8'h28, 8'hFC};
        logic [31:0] e[6] = '{32'h05, 32'h64, 32'h0A, 32'h01, 32'h0, 32'h0};
        logic [31:0] d;
        for (int i = 0; i < 6; i++) begin
            rd_reg(a[i], d);
            chk("reg", e[i], d);
        end
    endtask

    task automatic start_state(string n, input logic [31:0] c);
        logic [31:0] d;
        repeat (4) @(posedge clk_sys_i);
        wr_reg(dhs_pkg::ADDR_CTRL, c);
        repeat (8) @(posedge clk_sys_i);
        rd_reg(dhs_pkg::ADDR_STATUS, d);
        chk(n, 32'h0, {29'h0, d[2:0]});
    endtask

    task automatic t_refuse();
        logic [31:0] d;
        mode <= 1'b0;
        start_state("state_nomode", 32'h0000_0001);
        mode <= 1'b1;
        prog <= 4'h3;
        start_state("state_prog", 32'h0000_0001);
        prog <= 4'h0;
        // Pins need the synchroniser delay before a start is judged
        repeat (4) @(posedge clk_sys_i);
        wr_reg(dhs_pkg::ADDR_CTRL, 32'h0000_0001);
        rd_reg(dhs_pkg::ADDR_STATUS, d);
        chk("state_start", 32'h1, {29'h0, d[2:0]});
        start_state("state_abort", 32'h0000_0002);
        chk("speed_abort", 32'h0, {16'h0, spd});
    endtask

    task automatic run(input logic [4:0] m, input logic pol,
            input logic [15:0] p, input logic [15:0] s, input logic z,
            input int base, input logic al);
        logic [31:0] d;
        wr_reg(dhs_pkg::ADDR_METHOD, {27'h0, m});
        wr_reg(dhs_pkg::ADDR_POLARITY, {31'h0, pol});
        wr_reg(dhs_pkg::ADDR_POST_DOG, {16'h0, p});
        wr_reg(dhs_pkg::ADDR_SHIFT, {16'h0, s});
        pol_m <= pol;
        z_en <= z;
        clr <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        clr <= 1'b0;
        wr_reg(dhs_pkg::ADDR_CTRL, 32'h0000_0001);
        // Old complete or alarm level drops two edges after the start
        repeat (2) @(posedge clk_sys_i);
        for (int i = 0; i < 3000 && cmp !== 1'b1 && alm !== 1'b1; i++)
            @(posedge clk_sys_i);
        chk("alarm", {31'h0, al}, {31'h0, alm});
        chk("travel", 32'h1, {31'h0, trav >= base && trav <= base + 3});
        chk("dir", {31'h0, m[4]}, {31'h0, dir});
        chk("max_speed", 32'h14, {16'h0, mx});
        if (!al) begin
            chk("creep", 32'h05, {16'h0, lst});
            rd_reg(dhs_pkg::ADDR_POSITION, d);
            chk("position", 32'h1, {31'h0, d >= HOME - 1 && d <= HOME + 1});
            repeat (20) @(posedge clk_sys_i);
            chk("complete", 32'h1, {31'h0, cmp});
        end
    endtask

    task automatic t_irq();
        logic [31:0] d;
        wr_reg(dhs_pkg::ADDR_IRQ_ENABLE, 32'h0000_0001);
        repeat (3) @(posedge clk_sys_i);
        chk("irq_on", 32'h1, {31'h0, irq});
        wr_reg(dhs_pkg::ADDR_IRQ_ENABLE, 32'h0000_0000);
        repeat (3) @(posedge clk_sys_i);
        chk("irq_mask", 32'h0, {31'h0, irq});
        rd_reg(dhs_pkg::ADDR_IRQ_STATUS, d);
        chk("irq_events", 32'h7, d);
        wr_reg(dhs_pkg::ADDR_IRQ_CLEAR, 32'h0000_0007);
        rd_reg(dhs_pkg::ADDR_IRQ_STATUS, d);
        chk("irq_status", 32'h0, d);
        wr_reg(dhs_pkg::ADDR_IRQ_ENABLE, 32'h0000_0001);
        repeat (3) @(posedge clk_sys_i);
        chk("irq_clear", 32'h0, {31'h0, irq});
    endtask

    // Generous bound: every run finishes in a few hundred cycles
    initial begin
        repeat (40000) @(posedge clk_sys_i);
        num_errors++;
        end_sim();
    end

    initial begin
        repeat (2) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        t_regs();
        wr_reg(dhs_pkg::ADDR_HOME_SPEED, 32'h0000_0014);
        wr_reg(dhs_pkg::ADDR_CREEP_SPEED, 32'h0000_0005);
        wr_reg(dhs_pkg::ADDR_HOME_DATA, HOME);
        clr <= 1'b0;
        t_refuse();
        run(5'h05, 1'b1, 16'h0004, 16'h0003, 1'b0, 47, 1'b0);
        run(5'h16, 1'b0, 16'h0014, 16'h000A, 1'b1, 50, 1'b0);
        run(5'h06, 1'b1, 16'h0001, 16'h0001, 1'b1, 22, 1'b1);
        run(5'h07, 1'b1, 16'h0000, 16'h0000, 1'b1, 31, 1'b0);
        t_irq();
        end_sim();
    end
endmodule

`default_nettype wire
